// ---- core/stc_regs.vh ----
`ifndef STC_REGS_VH
`define STC_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define STC_CTRL_ADDR 8'h00
`define STC_COUNT_ADDR 8'h04
`define STC_PERIOD_ADDR 8'h08
`define STC_STATUS_ADDR 8'h0C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define STC_RUN_BIT 15
`define STC_SIDL_BIT 13
`define STC_GATE_BIT 6
`define STC_PS_HI_BIT 5
`define STC_PS_LO_BIT 4
`define STC_SYNC_BIT 2
`define STC_CS_BIT 1
// Writable control bits; all others read as zero
`define STC_CTRL_MASK 16'hA076

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define STC_MATCH_BIT 0
`define STC_GATE_LVL_BIT 1
`define STC_PIN_LVL_BIT 2
`define STC_MODE_LO_BIT 3
`define STC_MODE_HI_BIT 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define STC_CTRL_RST 16'h0000
`define STC_COUNT_RST 16'h0000
`define STC_PERIOD_RST 16'hFFFF

// ----------------------------------------
// Prescaler terminal counts (ratio minus one)
// ----------------------------------------
`define STC_PS1_TOP 8'h00
`define STC_PS8_TOP 8'h07
`define STC_PS64_TOP 8'h3F
`define STC_PS256_TOP 8'hFF

`endif

// ---- core/stc_sync3.v ----
`timescale 1ns/100ps

// ----------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------
module stc_sync3 (
   // Clock, enable and reset
   input wire clk,
   input wire ce,
   input wire rst_n,
   // Asynchronous input
   input wire din,
   // Filtered level and its rising edge
   output reg level_r,
   output reg rise_r
);

   reg s1_r;
   reg s2_r;
   reg s3_r;

   // First stage feeds the second stage only
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level_r <= 1'b0;
         rise_r <= 1'b0;
      end else if (ce) begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         rise_r <= 1'b0;
         // A change counts only once stages two and three agree
         if (s2_r == s3_r) begin
            level_r <= s3_r;
            rise_r <= s3_r & ~level_r;
         end
      end
   end

endmodule // stc_sync3

// ---- core/stc_timer.v ----
// Summary of operation
// - Sixteen-bit counter counts selected edges, wraps
// - Async counter mode counts synchronised pin edges, no alignment
// - Sync counter mode aligns after the prescaler
// - Timer and gated modes use internal clock
// - Counter modes use the external count pin
// - Control bit 1 selects the clock source
// - Control bit 2 selects external clock sync
// - Control bit 6 enables gated accumulation
// - Mode decoded from source, gate, sync bits
`timescale 1ns/100ps
`include "stc_regs.vh"

module stc_timer #(
   parameter ADR_W = 8
) (
   // Clock, enable and reset
   input wire clk,
   input wire ce,
   input wire resetn,
   // Wishbone classic slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [ADR_W-1:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // External count clock and gate pin
   input wire ext_count_clock_pin,
   // CPU idle indication
   input wire cpu_idle,
   // Timer state
   output reg [15:0] count_r,
   output reg period_match_r
);

   // ----------------------------------------
   // Mode codes
   // ----------------------------------------
   localparam MODE_TIMER = 2'b00;
   localparam MODE_GATED = 2'b01;
   localparam MODE_SYNC = 2'b10;
   localparam MODE_ASYNC = 2'b11;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   reg rst_s1_r;
   reg rst_n_r;

   // Assertion is immediate, release waits two edges
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // ----------------------------------------
   // Pin synchroniser
   // ----------------------------------------
   wire pin_level;
   wire pin_rise;

   stc_sync3 u_pin_sync (
      .clk(clk),
      .ce(ce),
      .rst_n(rst_n_r),
      .din(ext_count_clock_pin),
      .level_r(pin_level),
      .rise_r(pin_rise)
   );

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [15:0] timer_control_reg_r;
   reg [15:0] period_r;
   reg match_flag_r;
   reg [7:0] pre_cnt_r;
   reg pre_tick_q_r;

   wire timer_on_enable = timer_control_reg_r[`STC_RUN_BIT];
   wire stop_in_idle = timer_control_reg_r[`STC_SIDL_BIT];
   wire clock_source_select = timer_control_reg_r[`STC_CS_BIT];
   wire ext_clock_sync_enable = timer_control_reg_r[`STC_SYNC_BIT];
   wire gated_accumulate_enable = timer_control_reg_r[`STC_GATE_BIT];
   wire [1:0] ps_sel = timer_control_reg_r[`STC_PS_HI_BIT:`STC_PS_LO_BIT];

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   reg [1:0] mode;

   // Sync is ignored in timer modes, gate in counter modes
   always @* begin
      case ({clock_source_select, gated_accumulate_enable, ext_clock_sync_enable})
         3'b000, 3'b001: mode = MODE_TIMER;
         3'b010, 3'b011: mode = MODE_GATED;
         3'b101, 3'b111: mode = MODE_SYNC;
         3'b100, 3'b110: mode = MODE_ASYNC;
         default: mode = MODE_TIMER;
      endcase
   end

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire bus_req = wb_cyc_i & wb_stb_i;
   wire bus_wr = bus_req & wb_we_i & wb_ack_o;
   wire [7:0] adr8 = wb_adr_i[7:0];
   wire wr_ctrl = bus_wr & (adr8 == `STC_CTRL_ADDR);
   wire wr_count = bus_wr & (adr8 == `STC_COUNT_ADDR);
   wire wr_period = bus_wr & (adr8 == `STC_PERIOD_ADDR);
   wire wr_status = bus_wr & (adr8 == `STC_STATUS_ADDR);

   // Byte-lane merge for 16-bit registers
   function [15:0] lane_merge;
      input [15:0] old_val;
      input [15:0] new_val;
      input [1:0] sel;
      begin
         lane_merge[7:0] = sel[0] ? new_val[7:0] : old_val[7:0];
         lane_merge[15:8] = sel[1] ? new_val[15:8] : old_val[15:8];
      end
   endfunction

   // ----------------------------------------
   // Clock source and prescaler
   // ----------------------------------------
   wire running = timer_on_enable & ~(stop_in_idle & cpu_idle);
   reg src_tick;
   reg [7:0] ps_top;

   always @* begin
      case (mode)
         MODE_TIMER: src_tick = 1'b1;
         MODE_GATED: src_tick = pin_level;
         MODE_SYNC: src_tick = pin_rise;
         MODE_ASYNC: src_tick = pin_rise;
         default: src_tick = 1'b0;
      endcase
   end

   always @* begin
      case (ps_sel)
         2'b00: ps_top = `STC_PS1_TOP;
         2'b01: ps_top = `STC_PS8_TOP;
         2'b10: ps_top = `STC_PS64_TOP;
         2'b11: ps_top = `STC_PS256_TOP;
         default: ps_top = `STC_PS1_TOP;
      endcase
   end

   wire pre_tick = running & src_tick & (pre_cnt_r == ps_top);

   reg [7:0] pre_cnt_nxt;

   // Prescaler restarts on any control or count write so a new
   // setting never inherits a partial division
   always @* begin
      pre_cnt_nxt = pre_cnt_r;
      if (wr_ctrl | wr_count | ~running) begin
         pre_cnt_nxt = 8'h00;
      end else if (src_tick) begin
         if (pre_cnt_r == ps_top) begin
            pre_cnt_nxt = 8'h00;
         end else begin
            pre_cnt_nxt = pre_cnt_r + 8'h01;
         end
      end
   end

   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pre_cnt_r <= 8'h00;
         pre_tick_q_r <= 1'b0;
      end else if (ce) begin
         pre_cnt_r <= pre_cnt_nxt;
         // Alignment stage applied after the prescaler
         pre_tick_q_r <= pre_tick & running & ~wr_ctrl;
      end
   end

   // ----------------------------------------
   // Increment selection
   // ----------------------------------------
   reg inc;

   // With a single clock the async mode cannot bypass sampling; it
   // only skips the alignment stage, so it answers one cycle earlier

   always @* begin
      case (mode)
         MODE_SYNC: inc = pre_tick_q_r & running;
         MODE_ASYNC: inc = pre_tick;
         default: inc = pre_tick;
      endcase
   end

   wire hit = inc & (count_r == period_r);

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   reg [15:0] count_nxt;

   // A bus write to the count wins over an increment in the same cycle
   always @* begin
      count_nxt = count_r;
      if (wr_count) begin
         count_nxt = lane_merge(count_r, wb_dat_i[15:0], wb_sel_i[1:0]);
      end else if (hit) begin
         count_nxt = 16'h0000;
      end else if (inc) begin
         count_nxt = count_r + 16'h0001;
      end
   end

   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         count_r <= `STC_COUNT_RST;
         period_match_r <= 1'b0;
      end else if (ce) begin
         period_match_r <= hit;
         count_r <= count_nxt;
      end
   end

   // ----------------------------------------
   // Control, period and status registers
   // ----------------------------------------
   reg [15:0] ctrl_nxt;
   reg [15:0] period_nxt;
   reg match_flag_nxt;

   // New match wins over a write-one clear
   always @* begin
      ctrl_nxt = timer_control_reg_r;
      period_nxt = period_r;
      match_flag_nxt = match_flag_r;
      if (wr_ctrl) begin
         ctrl_nxt = lane_merge(timer_control_reg_r, wb_dat_i[15:0], wb_sel_i[1:0])
            & `STC_CTRL_MASK;
      end
      if (wr_period) begin
         period_nxt = lane_merge(period_r, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (hit) begin
         match_flag_nxt = 1'b1;
      end else if (wr_status & wb_sel_i[0] & wb_dat_i[`STC_MATCH_BIT]) begin
         match_flag_nxt = 1'b0;
      end
   end

   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         timer_control_reg_r <= `STC_CTRL_RST;
         period_r <= `STC_PERIOD_RST;
         match_flag_r <= 1'b0;
      end else if (ce) begin
         timer_control_reg_r <= ctrl_nxt;
         period_r <= period_nxt;
         match_flag_r <= match_flag_nxt;
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   reg [31:0] rd_data;

   always @* begin
      rd_data = 32'h0000_0000;
      case (adr8)
         `STC_CTRL_ADDR: rd_data[15:0] = timer_control_reg_r;
         `STC_COUNT_ADDR: rd_data[15:0] = count_r;
         `STC_PERIOD_ADDR: rd_data[15:0] = period_r;
         `STC_STATUS_ADDR: begin
            rd_data[`STC_MATCH_BIT] = match_flag_r;
            rd_data[`STC_GATE_LVL_BIT] = pin_level & gated_accumulate_enable;
            rd_data[`STC_PIN_LVL_BIT] = pin_level;
            rd_data[`STC_MODE_HI_BIT:`STC_MODE_LO_BIT] = mode;
         end
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------
   // Bus handshake
   // ----------------------------------------
   // One wait state; ack drops the cycle after it is given, so a
   // held request is never acknowledged in two consecutive cycles
   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce) begin
         wb_ack_o <= bus_req & ~wb_ack_o;
         if (bus_req & ~wb_ack_o & ~wb_we_i) begin
            wb_dat_o <= rd_data;
         end
      end
   end

endmodule // stc_timer

// ---- tb/stc_pin_src.sv ----
`timescale 1ns/100ps
module stc_pin_src (
   // Clock
   input wire clk,
   // Burst request and idle level
   input wire run,
   input wire idle_lvl,
   // Count clock or gate pin
   output logic pin
);
   logic [1:0] ph_r;
   initial pin = 1'b0;
   initial ph_r = 2'h0;
   // Period of eight clocks keeps well under the pin rate limit
   always @(posedge clk) begin
      if (run) begin
         ph_r <= ph_r + 2'h1;
         if (ph_r == 2'h3) pin <= ~pin;
      end else begin
         ph_r <= 2'h0;
         pin <= idle_lvl;
      end
   end
endmodule // stc_pin_src

// ---- tb/stc_timer_asserts.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// Bus handshake and counter checks
// ----------------------------------------
module stc_timer_asserts (
   // Clock and reset
   input wire clk,
   input wire ce,
   input wire resetn,
   // Bus
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   // Counter
   input wire [15:0] count_r,
   input wire period_match_r
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
   endsequence
   sequence s_ack;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_answer;
      s_req |-> ##1 s_ack;
   endproperty
   AST_ACK_AFTER_REQ: assert property (p_answer)
      else $error("request not answered in one cycle");
   AST_NO_STRAY_ACK: assert property (!(wb_cyc_i && wb_stb_i) && ce |=> !wb_ack_o)
      else $error("ack without request");
   AST_READ_UPPER_ZERO: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   AST_COUNT_STEP: assert property (ce && !(wb_ack_o && wb_we_i) |=>
      (count_r == $past(count_r) || count_r == $past(count_r) + 16'h0001 ||
      count_r == 16'h0000))
      else $error("counter moved by more than one");
   AST_CE_FREEZE: assert property (!ce |=> $stable(count_r))
      else $error("counter moved while frozen");
   AST_MATCH_WRAP: assert property (period_match_r |-> count_r <= 16'h0001)
      else $error("match pulse without wrap");
   AST_MATCH_PULSE: assert property (period_match_r && ce |=> !period_match_r)
      else $error("match pulse too long");
   AST_ACK_SINGLE: assert property (wb_ack_o && ce |=> !wb_ack_o)
      else $error("ack longer than one cycle");
endmodule // stc_timer_asserts

bind stc_timer stc_timer_asserts u_chk (.clk(clk), .ce(ce), .resetn(resetn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .count_r(count_r), .period_match_r(period_match_r));

// ---- tb/stc_timer_bench.sv ----
`timescale 1ns/100ps
module stc_timer_bench;
   logic clk = 1'b0, ce = 1'b1, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, dat_o, rdq, a;
   logic ack, pin, match, pin_run = 1'b0, pin_idle = 1'b0, cpu_idle = 1'b0;
   logic [15:0] count;
   int fail_count = 0, n_checks = 0;
   int match_seen = 0;
   always #2 clk = ~clk;
   always @(posedge clk) begin
      if (match === 1'b1) match_seen++;
   end
   stc_timer u_stc_timer (.clk(clk), .ce(ce), .resetn(resetn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .ext_count_clock_pin(pin),
      .cpu_idle(cpu_idle), .count_r(count), .period_match_r(match));
   stc_pin_src u_stc_pin_src (.clk(clk), .run(pin_run), .idle_lvl(pin_idle), .pin(pin));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rdq = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task rd2(output logic [31:0] first);
      wb(1'b0, 8'h04, 32'h0);
      first = rdq;
      wb(1'b0, 8'h04, 32'h0);
   endtask
   task t_regs;
      wb(1'b0, 8'h00, 32'h0); chk(rdq, 32'h0);
      wb(1'b0, 8'h08, 32'h0); chk(rdq, 32'h0000FFFF);
      wb(1'b0, 8'h10, 32'h0); chk(rdq, 32'h0);
      wb(1'b1, 8'h00, 32'hFFFFFFFF);
      wb(1'b0, 8'h00, 32'h0); chk(rdq, 32'h0000A076);
      $display("regs test done");
   endtask
   task t_modes;
      logic [15:0] cv [6];
      logic [1:0] mv [6];
      cv = '{16'h0000, 16'h0004, 16'h0040, 16'h0044, 16'h0006, 16'h0002};
      mv = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
      foreach (cv[i]) begin
         wb(1'b1, 8'h00, {16'h0, cv[i]});
         wb(1'b0, 8'h0C, 32'h0); chk(rdq[4:3], mv[i]);
      end
      $display("modes test done");
   endtask
   task t_timer;
      wb(1'b1, 8'h04, 32'h0);
      wb(1'b1, 8'h00, 32'h8000);
      rd2(a); chk(rdq - a, 32'h3);
      wb(1'b0, 8'h04, 32'h0);
      a = rdq;
      @(posedge clk);
      ce <= 1'b0;
      repeat (10) @(posedge clk);
      ce <= 1'b1;
      wb(1'b0, 8'h04, 32'h0); chk(rdq - a, 32'h4);
      cpu_idle <= 1'b1;
      wb(1'b1, 8'h00, 32'hA000);
      rd2(a); chk(rdq, a);
      cpu_idle <= 1'b0;
      wb(1'b1, 8'h00, 32'h0);
      rd2(a); chk(rdq, a);
      $display("timer test done");
   endtask
   task t_gate;
      wb(1'b1, 8'h00, 32'h8040);
      rd2(a); chk(rdq, a);
      pin_idle <= 1'b1;
      repeat (8) @(posedge clk);
      rd2(a); chk(rdq - a, 32'h3);
      pin_idle <= 1'b0;
      $display("gate test done");
   endtask
   task t_cnt(input logic [31:0] c, input int rises, input logic [31:0] e);
      wb(1'b1, 8'h00, 32'h0);
      wb(1'b1, 8'h04, 32'h0);
      wb(1'b1, 8'h00, c);
      pin_run <= 1'b1;
      repeat (rises * 8) @(posedge clk);
      pin_run <= 1'b0;
      repeat (20) @(posedge clk);
      wb(1'b0, 8'h04, 32'h0);
      chk(rdq, e);
      $display("counter test done");
   endtask
   task t_wrap;
      int m0;
      m0 = match_seen;
      wb(1'b1, 8'h08, 32'h4);
      wb(1'b1, 8'h04, 32'h0);
      wb(1'b1, 8'h00, 32'h8000);
      wb(1'b0, 8'h04, 32'h0); chk(rdq, 32'h1);
      wb(1'b0, 8'h04, 32'h0); chk(rdq, 32'h4);
      wb(1'b0, 8'h04, 32'h0); chk(rdq, 32'h2);
      wb(1'b1, 8'h00, 32'h0);
      chk(match_seen - m0, 32'h2);
      wb(1'b0, 8'h0C, 32'h0); chk(rdq, 32'h1);
      wb(1'b1, 8'h0C, 32'h1);
      wb(1'b0, 8'h0C, 32'h0); chk(rdq, 32'h0);
      wb(1'b1, 8'h08, 32'hFFFF);
      $display("wrap test done");
   endtask
   task final_report;
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      fail_count++;
      final_report;
   end
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      t_regs;
      t_modes;
      t_timer;
      t_gate;
      t_cnt(32'h8002, 10, 32'hA);
      t_cnt(32'h8006, 10, 32'hA);
      t_cnt(32'h8016, 16, 32'h2);
      t_wrap;
      final_report;
   end
endmodule // stc_timer_bench
